// File: logic/tern_mode_beeper.sv
// ternary mode decoder, continuity beeper control and register slave
//
// How it works
// - function input at upper supply decodes high: resistance mode.
// - open or common input decodes middle; function middle means voltage.
// - function input at lower supply decodes low: current mode.
// - group mA/uA/test, ohm-AC high-DC/low-AC/test, hold hold/auto/test.
// - active beeper toggles rail to rail, 2 kHz from 120 kHz crystal.
// - tone equals crystal over 60, internal clock over 30.
// - idle beeper output rests high at upper supply.
// - continuity comparator only on lowest ohm range; trip starts beeper.
// - beeper follows comparator directly, ignoring conversion phase.
// - internal clock is crystal over two; beeper divider runs on it.
`timescale 1ns/100ps
`default_nettype none

module tern_mode_beeper (
    // clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   srst_i,
    // ternary pin comparators, index by input
    input  wire logic [3:0]             tern_upper_i,
    input  wire logic [3:0]             tern_lower_i,
    // continuity sensing
    input  wire logic                   range_lowest_i,
    input  wire logic                   cont_trip_i,
    // decoded selections
    output logic                        func_ohms_o,
    output logic                        func_volts_o,
    output logic                        func_amps_o,
    output tern_beep_pkg::lvl_type      group_lvl_o,
    output tern_beep_pkg::lvl_type      ohmac_lvl_o,
    output tern_beep_pkg::lvl_type      hold_lvl_o,
    output logic                        cont_enable_o,
    // beeper drive
    output logic                        beep_o,
    // avalon-mm slave
    input  wire logic [3:0]             avs_address_i,
    input  wire logic                   avs_read_i,
    input  wire logic                   avs_write_i,
    input  wire logic [31:0]            avs_writedata_i,
    input  wire logic [3:0]             avs_byteenable_i,
    output logic [31:0]                 avs_readdata_o,
    output logic                        avs_waitrequest_o
);
    import tern_beep_pkg::*;

    typedef struct packed {
        logic [3:0] up_s1;
        logic [3:0] up_s2;
        logic [3:0] lo_s1;
        logic [3:0] lo_s2;
        lvl_type    grp;
        lvl_type    fn;
        lvl_type    ohmac;
        lvl_type    hold;
        logic       f_ohms;
        logic       f_volts;
        logic       f_amps;
        logic       cont_en;
        logic       trip;
        logic       beep_en;
        logic       allow;
        logic       force_on;
        logic       waitreq;
        logic [31:0] rdata;
    } main_state_type;

    main_state_type st;
    main_state_type next_st;

    beep_link_if link ();

    beep_tone_gen u_tone (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .link       (link.gen)
    );

    // a comparator pair that claims both rails is treated as the open state
    function automatic lvl_type decode_lvl(input logic up, input logic lo);
        lvl_type l;
        l = LVL_MID;
        if (up && !lo) begin
            l = LVL_HIGH;
        end else if (lo && !up) begin
            l = LVL_LOW;
        end
        return l;
    endfunction : decode_lvl

    logic [31:0] status_word;
    logic        bus_req;
    logic        bus_take;

    // status word shows decoder and beeper state
    always_comb begin
        status_word = 32'H0000_0000;
        status_word[ST_GROUP_LSB +: 2] = st.grp;
        status_word[ST_FUNC_LSB +: 2]  = st.fn;
        status_word[ST_OHMAC_LSB +: 2] = st.ohmac;
        status_word[ST_HOLD_LSB +: 2]  = st.hold;
        status_word[ST_CONT_EN]        = st.cont_en;
        status_word[ST_TRIP]           = st.trip;
        status_word[ST_BEEP]           = st.beep_en;
    end

    assign bus_req  = avs_read_i || avs_write_i;
    assign bus_take = bus_req && !st.waitreq;

    // next state: synchronisers, decode, continuity, bus
    always_comb begin
        next_st = st;
        // first stage feeds only the second stage
        next_st.up_s1 = tern_upper_i;
        next_st.lo_s1 = tern_lower_i;
        next_st.up_s2 = st.up_s1;
        next_st.lo_s2 = st.lo_s1;
        next_st.grp   = decode_lvl(st.up_s2[TERN_GROUP], st.lo_s2[TERN_GROUP]);
        next_st.fn    = decode_lvl(st.up_s2[TERN_FUNC], st.lo_s2[TERN_FUNC]);
        next_st.ohmac = decode_lvl(st.up_s2[TERN_OHMAC], st.lo_s2[TERN_OHMAC]);
        next_st.hold  = decode_lvl(st.up_s2[TERN_HOLD], st.lo_s2[TERN_HOLD]);
        next_st.f_ohms  = (st.fn == LVL_HIGH);
        next_st.f_volts = (st.fn == LVL_MID);
        next_st.f_amps  = (st.fn == LVL_LOW);
        // comparator live only on low-ohm group at its lowest range
        next_st.cont_en = st.f_ohms && (st.ohmac == LVL_MID) && range_lowest_i;
        next_st.trip    = st.cont_en && cont_trip_i;
        // no conversion phase enters here, so the tone enable rises on the edge after the trip
        next_st.beep_en = (st.cont_en && cont_trip_i && st.allow) || st.force_on;
        // one wait cycle per access, then the request is taken
        next_st.waitreq = 1'B1;
        if (bus_req && st.waitreq) begin
            next_st.waitreq = 1'B0;
            next_st.rdata   = RDATA_RST;
            if (avs_read_i) begin
                unique case (avs_address_i)
                    ADDR_STATUS:  next_st.rdata = status_word;
                    ADDR_CONTROL: begin
                        next_st.rdata[CTL_ALLOW] = st.allow;
                        next_st.rdata[CTL_FORCE] = st.force_on;
                    end
                    default:      next_st.rdata = RDATA_RST;
                endcase
            end
        end
        if (bus_take && avs_write_i && avs_address_i == ADDR_CONTROL
            && avs_byteenable_i[0]) begin
            next_st.allow = avs_writedata_i[CTL_ALLOW];
            next_st.force_on = avs_writedata_i[CTL_FORCE];
        end
    end

    // state register
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st         <= '0;
            st.grp     <= LVL_MID;
            st.fn      <= LVL_MID;
            st.ohmac   <= LVL_MID;
            st.hold    <= LVL_MID;
            st.f_volts <= 1'B1;
            st.allow   <= ALLOW_RST;
            st.force_on <= FORCE_RST;
            st.waitreq <= 1'B1;
            st.rdata   <= RDATA_RST;
        end else begin
            st <= next_st;
        end
    end

    assign link.enable       = st.beep_en;
    assign func_ohms_o       = st.f_ohms;
    assign func_volts_o      = st.f_volts;
    assign func_amps_o       = st.f_amps;
    assign group_lvl_o       = st.grp;
    assign ohmac_lvl_o       = st.ohmac;
    assign hold_lvl_o        = st.hold;
    assign cont_enable_o     = st.cont_en;
    assign beep_o            = link.tone;                       // tone flop in generator
    assign avs_readdata_o    = st.rdata;
    assign avs_waitrequest_o = st.waitreq;

    // decode latency: pin to function flags is four edges
    sequence s_pin_high_held;
        (tern_upper_i[TERN_FUNC] && !tern_lower_i[TERN_FUNC])[*4];
    endsequence

    property p_func_ohms;
        @(posedge core_clk_i) disable iff (srst_i)
        s_pin_high_held |=> func_ohms_o && !func_amps_o;
    endproperty
    a_func_ohms: assert property (p_func_ohms)
        else $error("function input at upper supply did not select ohms");

    property p_func_volts;
        @(posedge core_clk_i) disable iff (srst_i)
        (!tern_upper_i[TERN_FUNC] && !tern_lower_i[TERN_FUNC])[*4] |=> func_volts_o;
    endproperty
    a_func_volts: assert property (p_func_volts)
        else $error("open function input did not select volts");

    property p_func_amps;
        @(posedge core_clk_i) disable iff (srst_i)
        (tern_lower_i[TERN_FUNC] && !tern_upper_i[TERN_FUNC])[*4] |=> func_amps_o;
    endproperty
    a_func_amps: assert property (p_func_amps)
        else $error("function input at lower supply did not select amps");

    property p_hold_decode;
        @(posedge core_clk_i) disable iff (srst_i)
        (tern_upper_i[TERN_HOLD] && !tern_lower_i[TERN_HOLD])[*3] |=> hold_lvl_o == LVL_HIGH;
    endproperty
    a_hold_decode: assert property (p_hold_decode)
        else $error("hold input at upper supply did not decode high");

    property p_sync_depth;
        @(posedge core_clk_i) disable iff (srst_i)
        $changed(st.up_s2) |-> st.up_s2 == $past(tern_upper_i, 2);
    endproperty
    a_sync_depth: assert property (p_sync_depth)
        else $error("ternary level skipped a synchroniser stage");

    property p_cont_only_low_ohm;
        @(posedge core_clk_i) disable iff (srst_i)
        cont_enable_o |-> $past(func_ohms_o) && $past(ohmac_lvl_o == LVL_MID);
    endproperty
    a_cont_only_low_ohm: assert property (p_cont_only_low_ohm)
        else $error("continuity enabled outside lowest ohm range");

    property p_beep_direct;
        @(posedge core_clk_i) disable iff (srst_i)
        (cont_enable_o && cont_trip_i && st.allow) |=> link.enable;
    endproperty
    a_beep_direct: assert property (p_beep_direct)
        else $error("beeper did not start on comparator trip");

    property p_beep_idle_high;
        @(posedge core_clk_i) disable iff (srst_i)
        (!link.enable)[*2] |-> beep_o;
    endproperty
    a_beep_idle_high: assert property (p_beep_idle_high)
        else $error("idle beeper output not at upper level");

    // helper: cycles the tone enable has stood high, saturating
    logic [5:0] en_cycles;
    always_ff @(posedge core_clk_i) begin
        if (srst_i || !link.enable) begin
            en_cycles <= 6'H00;
        end else if (en_cycles != 6'H3F) begin
            en_cycles <= en_cycles + 6'H01;
        end
    end

    // a short enable pulse legally ends with no tone, so only a held enable is judged
    property p_tone_starts;
        @(posedge core_clk_i) disable iff (srst_i)
        (link.enable && en_cycles == 6'H1E) |-> !beep_o && $past(beep_o, 2);
    endproperty
    a_tone_starts: assert property (p_tone_starts)
        else $error("tone did not start within one half period");

    property p_bus_one_wait;
        @(posedge core_clk_i) disable iff (srst_i)
        (bus_req && avs_waitrequest_o) |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
    endproperty
    a_bus_one_wait: assert property (p_bus_one_wait)
        else $error("slave did not answer after one wait cycle");

    property p_no_early_fall;
        @(posedge core_clk_i) disable iff (srst_i)
        (link.enable && en_cycles < 6'H1C) |-> beep_o;
    endproperty
    a_no_early_fall: assert property (p_no_early_fall)
        else $error("tone fell before one half period");

    // the other selectors follow the same three-edge decode path
    property p_group_decode;
        @(posedge core_clk_i) disable iff (srst_i)
        (!tern_upper_i[TERN_GROUP] && !tern_lower_i[TERN_GROUP])[*3] |=> group_lvl_o == LVL_MID;
    endproperty
    a_group_decode: assert property (p_group_decode)
        else $error("open group input did not decode middle");

    property p_ohmac_decode;
        @(posedge core_clk_i) disable iff (srst_i)
        (tern_lower_i[TERN_OHMAC] && !tern_upper_i[TERN_OHMAC])[*3] |=> ohmac_lvl_o == LVL_LOW;
    endproperty
    a_ohmac_decode: assert property (p_ohmac_decode)
        else $error("ohm-ac input at lower supply did not decode low");

    property p_func_onehot;
        @(posedge core_clk_i) disable iff (srst_i)
        $onehot({func_ohms_o, func_volts_o, func_amps_o});
    endproperty
    a_func_onehot: assert property (p_func_onehot)
        else $error("function flags are not one-hot");

    property p_cont_needs_range;
        @(posedge core_clk_i) disable iff (srst_i)
        !range_lowest_i |=> !cont_enable_o;
    endproperty
    a_cont_needs_range: assert property (p_cont_needs_range)
        else $error("continuity enabled off the lowest range");

    property p_beep_stop;
        @(posedge core_clk_i) disable iff (srst_i)
        (!cont_trip_i && !st.force_on) |=> !link.enable;
    endproperty
    a_beep_stop: assert property (p_beep_stop)
        else $error("beeper did not stop when comparator released");

endmodule : tern_mode_beeper

`default_nettype wire

// File: logic/tern_beep_pkg.sv
// shared constants and types for the ternary mode decoder and beeper
package tern_beep_pkg;

    // decoded level of one three-level input
    typedef enum logic [1:0] {
        LVL_MID,
        LVL_HIGH,
        LVL_LOW
    } lvl_type;

    // index of each ternary input in the pin vectors
    localparam int TERN_COUNT = 4;
    localparam int TERN_GROUP = 0;
    localparam int TERN_FUNC  = 1;
    localparam int TERN_OHMAC = 2;
    localparam int TERN_HOLD  = 3;

    // clock division: internal clock is crystal / 2, tone is crystal / 60
    localparam int SYS_DIV         = 2;
    localparam int TONE_XTAL_DIV   = 60;
    localparam int HALF_TONE_INT   = TONE_XTAL_DIV / (SYS_DIV * 2);
    localparam logic [3:0] HALF_TONE_TICKS = 4'(HALF_TONE_INT);
    localparam logic [3:0] TICK_CNT_RST    = 4'H0;

    // register map, byte addresses
    localparam logic [3:0] ADDR_STATUS  = 4'H0;
    localparam logic [3:0] ADDR_CONTROL = 4'H4;

    // status register fields
    localparam int ST_GROUP_LSB = 0;
    localparam int ST_FUNC_LSB  = 2;
    localparam int ST_OHMAC_LSB = 4;
    localparam int ST_HOLD_LSB  = 6;
    localparam int ST_CONT_EN   = 8;
    localparam int ST_TRIP      = 9;
    localparam int ST_BEEP      = 10;

    // control register fields and values after reset
    localparam int CTL_ALLOW = 0;
    localparam int CTL_FORCE = 1;
    localparam logic ALLOW_RST = 1'B1;
    localparam logic FORCE_RST = 1'B0;

    localparam logic [31:0] RDATA_RST = 32'H0000_0000;
    localparam logic        TONE_RST  = 1'B1;

endpackage : tern_beep_pkg

// File: logic/beep_link_if.sv
// carrier between the mode decoder and the tone generator
`timescale 1ns/100ps
`default_nettype none

interface beep_link_if;
    logic enable;
    logic tone;

    modport gen (input enable, output tone);
    modport ctl (output enable, input tone);
endinterface : beep_link_if

`default_nettype wire

// File: logic/beep_tone_gen.sv
// beeper tone generator running off the half-rate internal clock
`timescale 1ns/100ps
`default_nettype none

module beep_tone_gen (
    // clock and reset
    input  wire logic   core_clk_i,
    input  wire logic   srst_i,
    // link to the decoder
    beep_link_if.gen    link
);
    import tern_beep_pkg::*;

    typedef struct packed {
        logic       phase;
        logic [3:0] cnt;
        logic       tone;
    } gen_state_type;

    gen_state_type st;
    gen_state_type next_st;

    // half-rate tick; the tone counter only advances on it
    always_comb begin
        next_st = st;
        next_st.phase = ~st.phase;
        if (!link.enable) begin
            next_st.cnt  = TICK_CNT_RST;
            next_st.tone = TONE_RST;
        end else if (st.phase) begin
            if (st.cnt == HALF_TONE_TICKS - 4'H1) begin
                next_st.cnt  = TICK_CNT_RST;
                next_st.tone = ~st.tone;
            end else begin
                next_st.cnt = st.cnt + 4'H1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st <= '{phase: 1'B0, cnt: TICK_CNT_RST, tone: TONE_RST};
        end else begin
            st <= next_st;
        end
    end

    assign link.tone = st.tone;

    // helper: core cycles since the last tone edge while enabled
    logic [5:0] run;
    logic       seen;
    always_ff @(posedge core_clk_i) begin
        if (srst_i || !link.enable) begin
            run  <= 6'H00;
            seen <= 1'B0;
        end else if (next_st.tone != st.tone) begin
            run  <= 6'H00;
            seen <= 1'B1;
        end else begin
            run <= run + 6'H01;
        end
    end

    property p_tone_half_period;
        @(posedge core_clk_i) disable iff (srst_i)
        (link.enable && seen && next_st.tone != st.tone) |-> run == 6'D29;
    endproperty
    a_tone_half_period: assert property (p_tone_half_period)
        else $error("beeper half period is not 30 crystal cycles");

    property p_phase_alternates;
        @(posedge core_clk_i) disable iff (srst_i)
        st.phase |=> !st.phase;
    endproperty
    a_phase_alternates: assert property (p_phase_alternates)
        else $error("internal clock phase does not divide by two");

endmodule : beep_tone_gen

`default_nettype wire

// File: test/switch_piezo_model.sv
// far-side model: three-position selector switches and piezo tone meter
`timescale 1ns/100ps
`default_nettype none

module switch_piezo_model
    import tern_beep_pkg::*;
(
    // clock
    input  wire logic       core_clk_i,
    // switch positions, two bits per input in level encoding
    input  wire logic [7:0] sw_i,
    // rail comparators seen by the device
    output logic [3:0]      upper_o,
    output logic [3:0]      lower_o,
    // piezo drive and its measurement
    input  wire logic       beep_i,
    output logic [7:0]      half_len_o,
    output logic [7:0]      toggles_o
);
    logic       last_beep;
    logic [7:0] run;

    // a switch at a rail fires one comparator; open rests at common, neither fires
    always_comb begin
        for (int i = 0; i < TERN_COUNT; i++) begin
            upper_o[i] = (sw_i[2*i +: 2] == 2'(LVL_HIGH));
            lower_o[i] = (sw_i[2*i +: 2] == 2'(LVL_LOW));
        end
    end

    // start from the idle rail so a stuck-low output shows as a toggle
    initial begin
        last_beep  = 1'B1;
        run        = 8'H00;
        half_len_o = 8'H00;
        toggles_o  = 8'H00;
    end

    // length of each beeper level in core cycles, saturating
    always @(posedge core_clk_i) begin
        if (beep_i !== last_beep) begin
            half_len_o <= run;
            toggles_o  <= toggles_o + 8'H01;
            run        <= 8'H01;
        end else begin
            run <= (run == 8'HFF) ? run : run + 8'H01;
        end
        last_beep <= beep_i;
    end
endmodule : switch_piezo_model

`default_nettype wire

// File: test/tb_ternary_mode_select_and_beeper.sv
// self-checking bench for the ternary decoder and continuity beeper
`timescale 1ns/100ps
`default_nettype none

module tb_ternary_mode_select_and_beeper;
    import tern_beep_pkg::*;
    logic        core_clk_i;
    logic        srst_i;
    logic [7:0]  sw;
    logic [3:0]  tup;
    logic [3:0]  tlo;
    logic        rng_low;
    logic        trip;
    logic        f_ohm;
    logic        f_volt;
    logic        f_amp;
    logic        cont_en;
    logic        beep;
    lvl_type     grp;
    lvl_type     oac;
    lvl_type     hld;
    logic [3:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0]  be;
    logic        wait_req;
    logic [7:0]  half_len;
    logic [7:0]  toggles;
    logic [31:0] q;
    int          err_count;
    int          checks_done;

    tern_mode_beeper u_dut (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .tern_upper_i(tup), .tern_lower_i(tlo),
        .range_lowest_i(rng_low), .cont_trip_i(trip), .func_ohms_o(f_ohm),
        .func_volts_o(f_volt), .func_amps_o(f_amp), .group_lvl_o(grp), .ohmac_lvl_o(oac),
        .hold_lvl_o(hld), .cont_enable_o(cont_en), .beep_o(beep), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req));

    switch_piezo_model u_far (
        .core_clk_i(core_clk_i), .sw_i(sw), .upper_o(tup), .lower_o(tlo),
        .beep_i(beep), .half_len_o(half_len), .toggles_o(toggles));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : cyc

    // one avalon transfer; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk_i);
        rd <= !w; wr <= w; addr <= a; wdata <= d; be <= 4'HF;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (wait_req !== 1'B0 && n < 50);
        q = rdata;
        rd <= 1'B0; wr <= 1'B0;
        if (n >= 50) chk("bus answer", 32'H1, 32'H0);
    endtask : bus

    task automatic set_sw(input lvl_type g, input lvl_type f, input lvl_type o, input lvl_type h);
        @(posedge core_clk_i);
        sw <= {2'(h), 2'(o), 2'(f), 2'(g)};
        cyc(6);
    endtask : set_sw

    // every level on every input, checked against the decode table
    task automatic t_decode;
        lvl_type l;
        for (int i = 0; i < 3; i++) begin
            l = lvl_type'(i);
            set_sw(l, l, l, l);
            chk("function", (l == LVL_HIGH) ? 32'H4 : (l == LVL_LOW) ? 32'H1 : 32'H2,
                32'({f_ohm, f_volt, f_amp}));
            chk("group", 32'(l), 32'(grp));
            chk("ohmac", 32'(l), 32'(oac));
            chk("hold", 32'(l), 32'(hld));
        end
        @(posedge core_clk_i);
        sw <= 8'H04;
        cyc(2);
        chk("function early", 32'H1, 32'({f_ohm, f_volt, f_amp}));
        cyc(4);
        chk("function late", 32'H4, 32'({f_ohm, f_volt, f_amp}));
    endtask : t_decode

    // status fields, control reset value, unmapped place
    task automatic t_regs;
        set_sw(LVL_HIGH, LVL_LOW, LVL_MID, LVL_LOW);
        bus(1'B0, ADDR_STATUS, 32'H0);
        chk("status", (32'H1 << ST_GROUP_LSB) | (32'H2 << ST_FUNC_LSB) | (32'H2 << ST_HOLD_LSB),
            q & 32'H7FF);
        bus(1'B0, ADDR_CONTROL, 32'H0);
        chk("control rst", 32'(ALLOW_RST) << CTL_ALLOW | 32'(FORCE_RST) << CTL_FORCE, q);
        bus(1'B1, 4'H8, 32'H0);
        bus(1'B0, 4'H8, 32'H0);
        chk("unmapped", RDATA_RST, q);
        bus(1'B0, ADDR_CONTROL, 32'H0);
        chk("control kept", 32'H1, q);
    endtask : t_regs

    // tone rate, idle level, start and stop from the comparator
    task automatic t_beep;
        int n;
        logic [7:0] t0;
        set_sw(LVL_MID, LVL_HIGH, LVL_MID, LVL_MID);
        @(posedge core_clk_i);
        rng_low <= 1'B1;
        cyc(3);
        chk("cont enable", 32'H1, 32'(cont_en));
        chk("beep idle", 32'H1, 32'(beep));
        t0 = toggles;
        @(posedge core_clk_i);
        trip <= 1'B1;
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (beep !== 1'B0 && n < 60);
        chk("first fall late", 32'H1, 32'(n <= 34));
        while (toggles != t0 + 8'H03 && n < 200) begin
            cyc(1);
            n++;
        end
        chk("half period", 32'(TONE_XTAL_DIV / 2), 32'(half_len));
        @(posedge core_clk_i);
        trip <= 1'B0;
        cyc(3);
        chk("beep stop", 32'H1, 32'(beep));
        @(posedge core_clk_i);
        rng_low <= 1'B0;
        trip <= 1'B1;
        t0 = toggles;
        cyc(70);
        chk("no beep off range", 32'(t0), 32'(toggles));
        set_sw(LVL_MID, LVL_HIGH, LVL_HIGH, LVL_MID);
        @(posedge core_clk_i);
        rng_low <= 1'B1;
        cyc(3);
        chk("hi ohm no cont", 32'H0, 32'(cont_en));
        bus(1'B1, ADDR_CONTROL, 32'H0);
        set_sw(LVL_MID, LVL_HIGH, LVL_MID, LVL_MID);
        chk("cont back", 32'H1, 32'(cont_en));
        t0 = toggles;
        cyc(70);
        chk("allow off", 32'(t0), 32'(toggles));
        // forced tone with the comparator released: one fall and one rise in 70 cycles
        bus(1'B1, ADDR_CONTROL, 32'H2);
        trip <= 1'B0;
        cyc(70);
        chk("force tone", 32'(t0 + 8'H02), 32'(toggles));
        bus(1'B0, ADDR_STATUS, 32'H0);
        chk("status beep", 32'H1 << ST_BEEP, q & (32'H1 << ST_BEEP));
        bus(1'B1, ADDR_CONTROL, 32'H1);
    endtask : t_beep

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    // 100 MHz core clock
    initial begin
        core_clk_i = 1'B0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #300000;
        err_count++;
        summarize();
    end

    initial begin
        err_count = 0; checks_done = 0; srst_i = 1'B1; sw = 8'H00; rng_low = 1'B0;
        trip = 1'B0; addr = 4'H0; rd = 1'B0; wr = 1'B0; wdata = 32'H0; be = 4'HF;
        repeat (12) @(posedge core_clk_i);
        srst_i <= 1'B0;
        cyc(1);
        chk("beep rst", 32'(TONE_RST), 32'(beep));
        chk("wait rst", 32'H1, 32'(wait_req));
        t_decode();
        t_regs();
        t_beep();
        summarize();
    end
endmodule : tb_ternary_mode_select_and_beeper

`default_nettype wire
